/* src/oes_pkg.sv */
// oes_pkg: constants, field positions and carrier types of the op execution sampling unit
// assumes one core clock domain; all pipeline events arrive on that clock
package oes_pkg;

  // widths
  localparam int CNT_W    = 27;
  localparam int MAXHI_W  = 7;
  localparam int MAXLO_W  = 16;
  localparam int PA_W     = 52;
  localparam int LFSR_W   = 16;
  localparam int RAND_W   = 7;

  // model-specific register indices
  localparam logic [31:0] OES_IDX_FETCH_CTL  = 32'h0000_0030;
  localparam logic [31:0] OES_IDX_FETCH_LIN  = 32'h0000_0031;
  localparam logic [31:0] OES_IDX_FETCH_PHYS = 32'h0000_0032;
  localparam logic [31:0] OES_IDX_OP_CTL     = 32'h0000_0033;
  localparam logic [31:0] OES_IDX_OP_RIP     = 32'h0000_0034;
  localparam logic [31:0] OES_IDX_OP_BRANCH  = 32'h0000_0035;

  // op sampling control fields
  localparam int OPC_CUR_LSB   = 32;
  localparam int OPC_CUR_MSB   = 58;
  localparam int OPC_MAXHI_LSB = 20;
  localparam int OPC_MAXHI_MSB = 26;
  localparam int OPC_SEL_BIT   = 19;
  localparam int OPC_VALID_BIT = 18;
  localparam int OPC_EN_BIT    = 17;
  localparam int OPC_MAXLO_MSB = 15;

  // fetch control flags and branch-data flag kept here
  localparam int FCT_VALID_BIT = 49;
  localparam int FCT_PAV_BIT   = 52;
  localparam int OBR_RIPINV_BIT = 38;

  // counter compare and abort reload split
  localparam int CNT_CMP_LSB   = 4;
  localparam int CNT_CLR_LSB   = 7;

  // random source
  localparam logic [LFSR_W-1:0] LFSR_SEED = 16'hACE1;
  localparam logic [LFSR_W-1:0] LFSR_TAPS = 16'hB400;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] index;
    logic [63:0] wdata;
  } oes_msr_req_t;

  typedef struct packed {
    logic        ack;
    logic        fault;
    logic [63:0] rdata;
  } oes_msr_rsp_t;

  typedef struct packed {
    logic        dispatch;
    logic        retire;
    logic        abort;
    logic        addr_invalid;
    logic [63:0] instr_addr;
  } oes_op_ev_t;

  typedef struct packed {
    logic            done;
    logic            phys_valid;
    logic [63:0]     lin_addr;
    logic [PA_W-1:0] phys_addr;
  } oes_fetch_ev_t;

  typedef enum logic [1:0] {
    OES_COUNT  = 2'b00,
    OES_TAGGED = 2'b01,
    OES_NOTIFY = 2'b10
  } oes_op_st_t;

endpackage

/* src/oes_lfsr.sv */
// oes_lfsr: free-running pseudo-random source for the abort reload value
// assumes sys_clk is the core clock and srst a synchronous reset
`timescale 1ns/10ps
module oes_lfsr (
  input  wire logic                        sys_clk,   // core clock
  input  wire logic                        srst,      // sync reset, high
  output logic [oes_pkg::RAND_W-1:0]       rand_out   // low bits of the shifter
);
  import oes_pkg::*;

  typedef struct packed {
    logic [LFSR_W-1:0] sr;
  } oes_lfsr_st_t;

  oes_lfsr_st_t st_reg;
  oes_lfsr_st_t st_next;

  // galois shift every core clock
  always_comb begin
    st_next = st_reg;
    st_next.sr = {1'b0, st_reg.sr[LFSR_W-1:1]} ^ (st_reg.sr[0] ? LFSR_TAPS : '0);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_reg.sr <= LFSR_SEED;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rand_out = st_reg.sr[RAND_W-1:0];

  lfsr_nonzero_a: assert property (@(posedge sys_clk) disable iff (srst)
    st_reg.sr != '0) else $error("random shifter locked at zero");

endmodule // oes_lfsr

/* src/oes_fetch_capture.sv */
// oes_fetch_capture: fetch sample flags and the captured fetch addresses
// assumes fetch completion events come from pipeline logic on the core clock
`timescale 1ns/10ps
module oes_fetch_capture (
  input  wire logic                  sys_clk,     // core clock
  input  wire logic                  srst,        // sync reset, high
  input  wire oes_pkg::oes_fetch_ev_t fetch_ev,   // tagged fetch completed or aborted
  input  wire logic                  ctl_we,      // software write of the fetch flags
  input  wire logic [63:0]           ctl_wdata,   // write data for the flags
  output logic                       f_valid,     // fetch sample valid
  output logic                       f_pav,       // fetch physical address valid
  output logic [63:0]                f_lin,       // linear address read value
  output logic [63:0]                f_phys       // physical address read value
);
  import oes_pkg::*;

  typedef struct packed {
    logic            valid;
    logic            pav;
    logic [63:0]     lin;
    logic [PA_W-1:0] phys;
  } oes_fcap_st_t;

  oes_fcap_st_t st_reg;
  oes_fcap_st_t st_next;
  logic         cap;

  // capture once per sample; the set wins over a software clear
  always_comb begin
    st_next = st_reg;
    cap = fetch_ev.done && !st_reg.valid;
    if (ctl_we) begin
      st_next.valid = ctl_wdata[FCT_VALID_BIT];
      st_next.pav   = ctl_wdata[FCT_PAV_BIT];
    end
    if (cap) begin
      st_next.valid = 1'b1;
      st_next.pav   = fetch_ev.phys_valid;
      st_next.lin   = fetch_ev.lin_addr;
      st_next.phys  = fetch_ev.phys_addr;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign f_valid = st_reg.valid;
  assign f_pav   = st_reg.pav;
  assign f_lin   = st_reg.lin;
  assign f_phys  = {{(64-PA_W){1'b0}}, st_reg.phys};

  fetch_set_a: assert property (@(posedge sys_clk) disable iff (srst)
    (fetch_ev.done && !st_reg.valid) |=> st_reg.valid && st_reg.lin == $past(fetch_ev.lin_addr))
    else $error("fetch completion did not set valid flag");

endmodule // oes_fetch_capture

/* src/oes_op_sampler.sv */
// oes_op_sampler: op interval counter, op tagging, retire capture and register access
// assumes pipeline events and register accesses are synchronous to sys_clk
`timescale 1ns/10ps

// Behaviour
// - fetch linear address register is read-only, holds tagged fetch address
// - fetch physical address register is read-only, defined when both valid flags set
// - physical address occupies bits 51:0, bits 63:52 read zero
// - counter counts clocks or dispatched ops while enabled and sample not valid; the code also holds it while an op is tagged
// - counter bits 26:4 matching maximum tags an op next cycle
// - retire captures results, sets valid, then raises interrupt request
// - counter holds while op sample valid flag is set
// - abort gives no sample, clears bits 26:7, randomises bits 6:0
// - after abort counting resumes and next match tags another op
// - current count field bits 58:32 reads live counter and is writable
// - maximum count is fields 26:20 and 15:0 joined for comparison
// - bit 19 selects clock cycles (0) or dispatched ops (1)
// - bit 17 enables execution sampling
// - op instruction address holds address of the tagged op's instruction
// - registers reached only through model-specific register reads and writes
// - fetch sample valid flag sets when tagged fetch completes or aborts
module oes_op_sampler (
  input  wire logic                   sys_clk,    // core clock, 250 MHz
  input  wire logic                   srst,       // sync reset, high
  input  wire oes_pkg::oes_msr_req_t  msr_req,    // register read or write request
  output oes_pkg::oes_msr_rsp_t       msr_rsp,    // registered answer, one cycle later
  input  wire oes_pkg::oes_op_ev_t    op_ev,      // dispatch, retire and abort events
  input  wire oes_pkg::oes_fetch_ev_t fetch_ev,   // tagged fetch capture event
  output logic                        op_tag,     // tag the next op, one-cycle pulse
  output logic                        op_irq      // interrupt request pulse
);
  import oes_pkg::*;

  typedef struct packed {
    oes_op_st_t         st;
    logic [CNT_W-1:0]   cnt;
    logic [MAXHI_W-1:0] max_hi;
    logic [MAXLO_W-1:0] max_lo;
    logic               sel;
    logic               valid;
    logic               en;
    logic [63:0]        rip;
    logic               rip_inv;
    logic               tag;
    logic               irq;
    oes_msr_rsp_t       rsp;
  } oes_op_state_t;

  oes_op_state_t      st_reg;
  oes_op_state_t      st_next;

  logic [RAND_W-1:0]  rand_val;
  logic               f_valid;
  logic               f_pav;
  logic [63:0]        f_lin;
  logic [63:0]        f_phys;

  logic               match;
  logic               counting;
  logic               incr;
  logic               wr_any;
  logic               wr_ctl;
  logic               wr_fctl;
  logic               rd_any;

  // pseudo-random low bits for the abort reload
  oes_lfsr u_lfsr (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .rand_out (rand_val)
  );

  // fetch flags and captured fetch addresses
  oes_fetch_capture u_fetch (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .fetch_ev  (fetch_ev),
    .ctl_we    (wr_fctl),
    .ctl_wdata (msr_req.wdata),
    .f_valid   (f_valid),
    .f_pav     (f_pav),
    .f_lin     (f_lin),
    .f_phys    (f_phys)
  );

  // request decode
  assign wr_any  = msr_req.valid && msr_req.write;
  assign rd_any  = msr_req.valid && !msr_req.write;
  assign wr_ctl  = wr_any && (msr_req.index == OES_IDX_OP_CTL);
  assign wr_fctl = wr_any && (msr_req.index == OES_IDX_FETCH_CTL);

  // compare against the two maximum fields joined
  assign match    = st_reg.cnt[CNT_W-1:CNT_CMP_LSB] == {st_reg.max_hi, st_reg.max_lo};
  assign counting = st_reg.en && !st_reg.valid && (st_reg.st == OES_COUNT);
  assign incr     = st_reg.sel ? op_ev.dispatch : 1'b1;

  // next-state: sampling sequence, then register writes, then reads
  always_comb begin
    st_next     = st_reg;
    st_next.tag = 1'b0;
    st_next.irq = 1'b0;
    st_next.rsp = '0;

    unique case (st_reg.st)
      OES_COUNT: begin
        if (counting) begin
          if (match) begin
            st_next.tag = 1'b1;
            st_next.st  = OES_TAGGED;
          end else if (incr) begin
            st_next.cnt = st_reg.cnt + 27'h1;
          end
        end
      end
      OES_TAGGED: begin
        if (op_ev.retire) begin
          st_next.rip     = op_ev.instr_addr;
          st_next.rip_inv = op_ev.addr_invalid;
          st_next.valid   = 1'b1;
          st_next.st      = OES_NOTIFY;
        end else if (op_ev.abort) begin
          st_next.cnt = {{(CNT_W-CNT_CLR_LSB){1'b0}}, rand_val};
          st_next.st  = OES_COUNT;
        end else if (!st_reg.en) begin
          st_next.st = OES_COUNT;
        end
      end
      OES_NOTIFY: begin
        st_next.irq = 1'b1;
        st_next.st  = OES_COUNT;
      end
      default: begin
        st_next.st = OES_COUNT;
      end
    endcase

    // software writes; a retire in the same cycle keeps the valid flag set
    if (wr_any) begin
      unique case (msr_req.index)
        OES_IDX_OP_CTL: begin
          st_next.cnt    = msr_req.wdata[OPC_CUR_MSB:OPC_CUR_LSB];
          st_next.max_hi = msr_req.wdata[OPC_MAXHI_MSB:OPC_MAXHI_LSB];
          st_next.max_lo = msr_req.wdata[OPC_MAXLO_MSB:0];
          st_next.sel    = msr_req.wdata[OPC_SEL_BIT];
          st_next.en     = msr_req.wdata[OPC_EN_BIT];
          st_next.valid  = msr_req.wdata[OPC_VALID_BIT] ||
                           (st_reg.st == OES_TAGGED && op_ev.retire);
        end
        OES_IDX_OP_RIP: begin
          st_next.rip = msr_req.wdata;
        end
        OES_IDX_OP_BRANCH: begin
          st_next.rip_inv = msr_req.wdata[OBR_RIPINV_BIT];
        end
        OES_IDX_FETCH_CTL: begin
          st_next.rsp.fault = 1'b0;
        end
        OES_IDX_FETCH_LIN, OES_IDX_FETCH_PHYS: begin
          st_next.rsp.fault = 1'b1;
        end
        default: begin
          st_next.rsp.fault = 1'b1;
        end
      endcase
    end

    // register reads
    if (rd_any) begin
      unique case (msr_req.index)
        OES_IDX_OP_CTL: begin
          st_next.rsp.rdata[OPC_CUR_MSB:OPC_CUR_LSB]     = st_reg.cnt;
          st_next.rsp.rdata[OPC_MAXHI_MSB:OPC_MAXHI_LSB] = st_reg.max_hi;
          st_next.rsp.rdata[OPC_SEL_BIT]                 = st_reg.sel;
          st_next.rsp.rdata[OPC_VALID_BIT]               = st_reg.valid;
          st_next.rsp.rdata[OPC_EN_BIT]                  = st_reg.en;
          st_next.rsp.rdata[OPC_MAXLO_MSB:0]             = st_reg.max_lo;
        end
        OES_IDX_OP_RIP: begin
          st_next.rsp.rdata = st_reg.rip;
        end
        OES_IDX_OP_BRANCH: begin
          st_next.rsp.rdata[OBR_RIPINV_BIT] = st_reg.rip_inv;
        end
        OES_IDX_FETCH_CTL: begin
          st_next.rsp.rdata[FCT_VALID_BIT] = f_valid;
          st_next.rsp.rdata[FCT_PAV_BIT]   = f_pav;
        end
        OES_IDX_FETCH_LIN: begin
          st_next.rsp.rdata = f_lin;
        end
        OES_IDX_FETCH_PHYS: begin
          st_next.rsp.rdata = f_phys;
        end
        default: begin
          st_next.rsp.fault = 1'b1;
        end
      endcase
    end
    st_next.rsp.ack = msr_req.valid;
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state flops
  assign op_tag  = st_reg.tag;
  assign op_irq  = st_reg.irq;
  assign msr_rsp = st_reg.rsp;

  // checks on the sampling sequence and register answers
  tag_after_match_a: assert property (@(posedge sys_clk) disable iff (srst)
    (counting && match) |=> op_tag && st_reg.st == OES_TAGGED)
    else $error("match did not tag an op in the next cycle");

  irq_after_valid_a: assert property (@(posedge sys_clk) disable iff (srst)
    (st_reg.st == OES_TAGGED && op_ev.retire) |=> st_reg.valid && !op_irq ##1 op_irq)
    else $error("interrupt request not one cycle after valid set");

  count_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
    (st_reg.valid && !wr_ctl) |=> $stable(st_reg.cnt))
    else $error("counter moved while sample valid");

  count_incr_a: assert property (@(posedge sys_clk) disable iff (srst)
    (counting && !match && incr && !wr_ctl) |=> st_reg.cnt == $past(st_reg.cnt) + 27'h1)
    else $error("counter did not increment");

  op_select_a: assert property (@(posedge sys_clk) disable iff (srst)
    (counting && !match && st_reg.sel && !op_ev.dispatch && !wr_ctl) |=> $stable(st_reg.cnt))
    else $error("counter moved without a dispatched op");

  abort_reload_a: assert property (@(posedge sys_clk) disable iff (srst)
    (st_reg.st == OES_TAGGED && op_ev.abort && !op_ev.retire && !wr_ctl)
    |=> st_reg.cnt[CNT_W-1:CNT_CLR_LSB] == '0 && !st_reg.valid && st_reg.st == OES_COUNT)
    else $error("abort did not reload the counter");

  disabled_quiet_a: assert property (@(posedge sys_clk) disable iff (srst)
    (!st_reg.en && !wr_ctl) |=> !op_tag)
    else $error("op tagged while sampling disabled");

  rip_capture_a: assert property (@(posedge sys_clk) disable iff (srst)
    (st_reg.st == OES_TAGGED && op_ev.retire && !wr_any) |=> st_reg.rip == $past(op_ev.instr_addr))
    else $error("instruction address not captured at retire");

  count_read_a: assert property (@(posedge sys_clk) disable iff (srst)
    (rd_any && msr_req.index == OES_IDX_OP_CTL)
    |=> msr_rsp.ack && msr_rsp.rdata[OPC_CUR_MSB:OPC_CUR_LSB] == $past(st_reg.cnt))
    else $error("current count read wrong");

  phys_upper_a: assert property (@(posedge sys_clk) disable iff (srst)
    (rd_any && msr_req.index == OES_IDX_FETCH_PHYS) |=> msr_rsp.rdata[63:PA_W] == '0)
    else $error("physical address reserved bits not zero");

  // pulse widths: the pipeline and the interrupt controller act on every high cycle
  tag_pulse_a: assert property (@(posedge sys_clk) disable iff (srst)
    op_tag |=> !op_tag)
    else $error("tag request longer than one cycle");

  tag_needs_en_a: assert property (@(posedge sys_clk) disable iff (srst)
    op_tag |-> $past(st_reg.en) && !$past(st_reg.valid))
    else $error("op tagged while disabled or sample valid");

  irq_pulse_a: assert property (@(posedge sys_clk) disable iff (srst)
    op_irq |=> !op_irq)
    else $error("interrupt request longer than one cycle");

  irq_after_set_a: assert property (@(posedge sys_clk) disable iff (srst)
    op_irq |-> $past(st_reg.valid))
    else $error("interrupt request before the sample was complete");

  // register answers: one per request, nothing in between
  ack_follow_a: assert property (@(posedge sys_clk) disable iff (srst)
    msr_req.valid |=> msr_rsp.ack)
    else $error("register request not answered");

  ack_quiet_a: assert property (@(posedge sys_clk) disable iff (srst)
    !msr_req.valid |=> !msr_rsp.ack && msr_rsp.rdata == '0)
    else $error("answer without a register request");

  ro_write_a: assert property (@(posedge sys_clk) disable iff (srst)
    (wr_any && (msr_req.index == OES_IDX_FETCH_LIN || msr_req.index == OES_IDX_FETCH_PHYS))
    |=> msr_rsp.fault)
    else $error("write to a read-only fetch address not refused");

  lin_read_a: assert property (@(posedge sys_clk) disable iff (srst)
    (rd_any && msr_req.index == OES_IDX_FETCH_LIN) |=> msr_rsp.rdata == $past(f_lin))
    else $error("fetch linear address read wrong");

  rip_read_a: assert property (@(posedge sys_clk) disable iff (srst)
    (rd_any && msr_req.index == OES_IDX_OP_RIP) |=> msr_rsp.rdata == $past(st_reg.rip))
    else $error("instruction address read wrong");

  // software writes of the count, maximum and mode fields win over the hardware in the same cycle
  cnt_write_a: assert property (@(posedge sys_clk) disable iff (srst)
    wr_ctl |=> st_reg.cnt == $past(msr_req.wdata[OPC_CUR_MSB:OPC_CUR_LSB]))
    else $error("current count write lost");

  max_write_a: assert property (@(posedge sys_clk) disable iff (srst)
    wr_ctl |=> st_reg.max_hi == $past(msr_req.wdata[OPC_MAXHI_MSB:OPC_MAXHI_LSB])
    && st_reg.max_lo == $past(msr_req.wdata[OPC_MAXLO_MSB:0]))
    else $error("maximum count fields not written");

  mode_write_a: assert property (@(posedge sys_clk) disable iff (srst)
    wr_ctl |=> st_reg.en == $past(msr_req.wdata[OPC_EN_BIT])
    && st_reg.sel == $past(msr_req.wdata[OPC_SEL_BIT]))
    else $error("enable or count select not written");

endmodule // oes_op_sampler

/* test/oes_pipe_model.sv */
// oes_pipe_model: pipeline and interrupt controller stand-in for the op sampler
// assumes op_tag and op_irq are one-cycle pulses on sys_clk, events change at falling edge
`timescale 1ns/10ps
module oes_pipe_model #(
  parameter logic [63:0] TAG_ADDR = 64'hFFFF_8000_0000_4ABC, // instruction of the tagged op
  parameter int          RET_DLY  = 3                         // cycles the tagged op takes
) (
  input  wire logic           sys_clk,     // core clock
  input  wire logic           srst,        // sync reset, high
  input  wire logic           op_tag,      // tag request from the sampler
  input  wire logic           op_irq,      // interrupt request from the sampler
  input  wire logic           dispatch_on, // dispatch one op every cycle
  input  wire logic           abort_next,  // next tagged op aborts
  output oes_pkg::oes_op_ev_t op_ev,       // pipeline events
  output int                  irq_cnt      // interrupts taken
);
  import oes_pkg::*;
  int   wait_q = -1;
  logic kill   = 1'h0;
  // tagged op leaves after RET_DLY cycles; address lines carry junk off the pulse
  // each line is written once per edge so no glitch reaches the sampler
  always @(negedge sys_clk) begin
    logic fire;
    fire = !srst && !op_tag && wait_q == 0;
    op_ev.dispatch = dispatch_on;
    op_ev.retire = fire && !kill;
    op_ev.abort = fire && kill;
    op_ev.addr_invalid = fire ? 1'h0 : ~op_ev.addr_invalid;
    op_ev.instr_addr = fire ? TAG_ADDR : ~op_ev.instr_addr;
    if (op_irq)
      irq_cnt++;
    if (srst)
      wait_q = -1;
    else if (op_tag) begin
      wait_q = RET_DLY;
      kill = abort_next;
    end else if (wait_q >= 0)
      wait_q--;
  end
endmodule // oes_pipe_model

/* test/op_execution_sampling_unit_bench.sv */
// op_execution_sampling_unit_bench: self-checking bench of the op sampler
// assumes oes_pkg, oes_op_sampler and oes_pipe_model are compiled before it
`timescale 1ns/10ps
module op_execution_sampling_unit_bench;
  import oes_pkg::*;
  localparam logic [63:0] TAG_ADDR = 64'hFFFF_8000_0000_4ABC;
  typedef struct {
    logic        wr;
    logic [31:0] idx;
    logic [63:0] wd;
    logic        flt;
    logic [63:0] rd;
  } oes_row_t;
  logic          sys_clk;
  logic          srst;
  oes_msr_req_t  msr_req;
  oes_msr_rsp_t  msr_rsp;
  oes_msr_rsp_t  rsp_q;
  oes_op_ev_t    op_ev;
  oes_fetch_ev_t fetch_ev;
  logic          op_tag;
  logic          op_irq;
  logic          dispatch_on;
  logic          abort_next;
  logic [63:0]   rd1;
  int            irq_cnt;
  int            errors;
  int            n_compared;
  // register accesses: request, then expected answer
  oes_row_t rows [10] = '{
    '{1'h0, OES_IDX_OP_CTL,     64'h0, 1'h0, 64'h0},
    '{1'h0, OES_IDX_FETCH_CTL,  64'h0, 1'h0, 64'h0},
    '{1'h0, 32'h0000_0036,      64'h0, 1'h1, 64'h0},
    '{1'h1, OES_IDX_FETCH_LIN,  64'h1234, 1'h1, 64'h0},
    '{1'h1, OES_IDX_FETCH_PHYS, 64'h1234, 1'h1, 64'h0},
    '{1'h0, OES_IDX_FETCH_LIN,  64'h0, 1'h0, 64'h0},
    '{1'h1, OES_IDX_OP_RIP, 64'h0123_4567_89AB_CDEF, 1'h0, 64'h0},
    '{1'h0, OES_IDX_OP_RIP, 64'h0, 1'h0, 64'h0123_4567_89AB_CDEF},
    '{1'h1, OES_IDX_OP_CTL, 64'h0000_0123_0558_BEEF, 1'h0, 64'h0},
    '{1'h0, OES_IDX_OP_CTL, 64'h0, 1'h0, 64'h0000_0123_0558_BEEF}
  };

  oes_op_sampler dut_u (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .msr_req  (msr_req),
    .msr_rsp  (msr_rsp),
    .op_ev    (op_ev),
    .fetch_ev (fetch_ev),
    .op_tag   (op_tag),
    .op_irq   (op_irq)
  );
  oes_pipe_model #(.TAG_ADDR(TAG_ADDR), .RET_DLY(3)) pipe_u (
    .sys_clk     (sys_clk),
    .srst        (srst),
    .op_tag      (op_tag),
    .op_irq      (op_irq),
    .dispatch_on (dispatch_on),
    .abort_next  (abort_next),
    .op_ev       (op_ev),
    .irq_cnt     (irq_cnt)
  );

  // 250 MHz core clock
  initial begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic chk_word(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask
  // one register access; answer is sampled the cycle after it is taken
  task automatic msr(input logic wr, input logic [31:0] idx, input logic [63:0] wd);
    @(negedge sys_clk);
    msr_req = '{valid:1'h1, write:wr, index:idx, wdata:wd};
    @(negedge sys_clk);
    rsp_q = msr_rsp;
    msr_req.valid = 1'h0;
    chk_bit(rsp_q.ack, 1'h1);
  endtask
  // tagged fetch ends; lines take the inverse once the pulse is over
  task automatic fetch_done(input logic [63:0] lin, input logic pav);
    @(negedge sys_clk);
    fetch_ev = '{done:1'h1, phys_valid:pav, lin_addr:lin, phys_addr:'1};
    @(negedge sys_clk);
    fetch_ev = '{done:1'h0, phys_valid:~pav, lin_addr:~lin, phys_addr:'0};
  endtask
  task automatic wait_tag(input int lim);
    for (int i = 0; i < lim && op_tag !== 1'h1; i++)
      @(negedge sys_clk);
    chk_bit(op_tag, 1'h1);
  endtask
  task automatic wait_irq(input int n, input int lim);
    for (int i = 0; i < lim && irq_cnt < n; i++)
      @(negedge sys_clk);
    chk_word(64'(irq_cnt), 64'(n));
  endtask
  task automatic results;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // watchdog: the whole run needs well under 2000 cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    $display("Error at %0t: watchdog expired", $time);
    results();
  end

  // main sequence
  initial begin
    srst = 1'h1;
    msr_req = '0;
    fetch_ev = '0;
    dispatch_on = 1'h0;
    abort_next = 1'h0;
    errors = 0;
    n_compared = 0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    srst = 1'h0;
    // reset values, faults, read-only and read-back rows
    foreach (rows[k]) begin
      msr(rows[k].wr, rows[k].idx, rows[k].wd);
      chk_bit(rsp_q.fault, rows[k].flt);
      chk_word(rsp_q.rdata, rows[k].rd);
    end
    // fetch capture, second completion ignored while valid is set
    fetch_done(64'hFFFF_8000_1234_5678, 1'h1);
    fetch_done(64'h0000_7FFF_0000_0040, 1'h0);
    msr(1'h0, OES_IDX_FETCH_CTL, 64'h0);
    chk_word(rsp_q.rdata, 64'h0012_0000_0000_0000);
    msr(1'h0, OES_IDX_FETCH_LIN, 64'h0);
    chk_word(rsp_q.rdata, 64'hFFFF_8000_1234_5678);
    msr(1'h0, OES_IDX_FETCH_PHYS, 64'h0);
    chk_word(rsp_q.rdata, 64'h000F_FFFF_FFFF_FFFF);
    // clock counting with a split maximum, tagged op retires
    msr(1'h1, OES_IDX_OP_CTL, 64'h0010_001C_0012_0002);
    wait_tag(12);
    wait_irq(1, 20);
    msr(1'h0, OES_IDX_OP_CTL, 64'h0);
    rd1 = rsp_q.rdata;
    chk_bit(rd1[OPC_VALID_BIT], 1'h1);
    chk_word(64'(rd1[58:36]), 64'h0001_0002);
    repeat (4) @(negedge sys_clk);
    msr(1'h0, OES_IDX_OP_CTL, 64'h0);
    chk_word(rsp_q.rdata, rd1);
    msr(1'h0, OES_IDX_OP_RIP, 64'h0);
    chk_word(rsp_q.rdata, TAG_ADDR);
    msr(1'h0, OES_IDX_OP_BRANCH, 64'h0);
    chk_word(rsp_q.rdata, 64'h0);
    // restart counting dispatched ops; first tagged op aborts
    abort_next = 1'h1;
    msr(1'h1, OES_IDX_OP_CTL, 64'h0000_006F_000A_0007);
    repeat (3) @(negedge sys_clk);
    msr(1'h0, OES_IDX_OP_CTL, 64'h0);
    chk_word(rsp_q.rdata, 64'h0000_006F_000A_0007);
    dispatch_on = 1'h1;
    wait_tag(6);
    @(negedge sys_clk);
    abort_next = 1'h0;
    repeat (5) @(negedge sys_clk);
    chk_word(64'(irq_cnt), 64'h1);
    msr(1'h0, OES_IDX_OP_CTL, 64'h0);
    chk_word(64'(rsp_q.rdata[58:39]), 64'h0);
    wait_irq(2, 300);
    msr(1'h0, OES_IDX_OP_CTL, 64'h0);
    chk_word(64'(rsp_q.rdata[58:36]), 64'h7);
    // reset in mid-run returns the op and fetch control registers to zero
    srst = 1'h1;
    repeat (3) @(negedge sys_clk);
    srst = 1'h0;
    chk_bit(op_irq, 1'h0);
    msr(1'h0, OES_IDX_OP_CTL, 64'h0);
    chk_word(rsp_q.rdata, 64'h0);
    msr(1'h0, OES_IDX_FETCH_CTL, 64'h0);
    chk_word(rsp_q.rdata, 64'h0);
    results();
  end
endmodule // op_execution_sampling_unit_bench
